// [ir_emitter_model.sv]
// Emitter model: counts carrier pulses and the length of each high run.
// Assumes the drive is active high and synchronous to pclk.
`timescale 1ns/1ps
module ir_emitter_model (
   input  wire logic pclk,      // Clock
   input  wire logic presetn,   // Reset, active low
   input  wire logic clr,       // Clear the counters
   input  wire logic ir_tx_out, // Emitter drive
   output int        pulses,    // Rising edges seen
   output int        high_len   // Length of last high run
);
   // ========================================================
   // Pulse counting
   int   run;
   logic prev;

   // Count rising edges; a run is recorded once the drive falls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulses   <= 0;
         high_len <= 0;
         run      <= 0;
         prev     <= 1'b0;
      end else if (clr) begin
         pulses   <= 0;
         high_len <= 0;
         run      <= 0;
         prev     <= ir_tx_out;
      end else begin
         prev <= ir_tx_out;
         if (ir_tx_out && !prev)
            pulses <= pulses + 1;
         if (ir_tx_out)
            run <= run + 1;
         else if (prev) begin
            high_len <= run;
            run      <= 0;
         end
      end
   end
endmodule

// [ir_tx_ctrl.sv]
// Infrared transmit controller: APB registers, FIFO, run-length and
// carrier modulation onto one emitter output.
// Assumes APB signals synchronous to pclk and a 250 MHz clock.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

module ir_tx_ctrl (
   input  wire logic        pclk,     // APB clock
   input  wire logic        presetn,  // Async reset, active low
   input  wire logic        psel,     // APB select
   input  wire logic        penable,  // APB access phase
   input  wire logic        pwrite,   // APB direction
   input  wire logic [11:0] paddr,    // APB byte address
   input  wire logic [31:0] pwdata,   // APB write data
   output logic [31:0]      prdata,   // APB read data
   output logic             pready,   // APB ready
   output logic             pslverr,  // APB error on unmapped
   output logic             ir_tx_out,  // Modulated emitter drive
   output logic             loop_out,   // Loopback copy of carrier
   output logic             irq         // Level interrupt
);
   // ==========================================================
   // Registers and state
   logic [7:0]  ctrl1_reg;
   logic [7:0]  ctrl2_reg;
   logic [15:0] period_reg;
   logic        band_reg;
   logic        lowirq_en_reg;
   logic [2:0]  irq_stat_reg;
   logic [2:0]  irq_mask_reg;
   logic [31:0] prdata_reg;
   logic [7:0]  fifo_mem [ir_tx_pkg::FIFO_DEPTH];
   logic [4:0]  wr_ptr_reg;
   logic [4:0]  rd_ptr_reg;
   logic [5:0]  count_reg;
   ir_tx_pkg::tx_state_t state_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  bits_left_reg;
   logic        runlen_byte_reg;
   logic [15:0] bit_cnt_reg;
   logic [15:0] car_cnt_reg;
   logic [3:0]  pulse_cnt_reg;
   logic [11:0] idle_cnt_reg;
   logic        tx_mod_reg;

   // ==========================================================
   // APB decode
   wire        wr_en   = psel & penable & pwrite;
   wire        rd_setup = psel & ~penable & ~pwrite;
   wire [7:0]  idx     = 8'(paddr[11:2]);
   wire        hit_c1  = idx == ir_tx_pkg::TX_CTRL1_IDX;
   wire        hit_c2  = idx == ir_tx_pkg::TX_CTRL2_IDX;
   wire        hit_dat = idx == ir_tx_pkg::TX_DATA_IDX;
   wire        hit_st  = idx == ir_tx_pkg::TX_STAT_IDX;
   wire        hit_is  = idx == ir_tx_pkg::IRQ_STAT_IDX;
   wire        hit_im  = idx == ir_tx_pkg::IRQ_MASK_IDX;
   wire        hit_aux = idx == ir_tx_pkg::AUX_CTRL_IDX;
   wire        mapped  = hit_c1 | hit_c2 | hit_dat | hit_st | hit_is |
                         hit_im | hit_aux;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Control fields
   wire       flush_req  = wr_en & hit_c1 & pwdata[ir_tx_pkg::FLUSH_BIT];
   wire       loop_en    = ctrl1_reg[ir_tx_pkg::LOOP_BIT];
   wire [1:0] level_sel  = ctrl1_reg[ir_tx_pkg::LEVEL_LSB +: 2];
   wire       runlen_en  = ctrl1_reg[ir_tx_pkg::RUNLEN_BIT];
   wire       defer_en   = ctrl1_reg[ir_tx_pkg::DEFER_BIT];
   wire [1:0] style      = ctrl1_reg[ir_tx_pkg::STYLE_LSB +: 2];
   wire [4:0] freq_code  = ctrl2_reg[ir_tx_pkg::FREQ_LSB +: 5];
   wire [2:0] width_sel  = ctrl2_reg[ir_tx_pkg::WIDTH_LSB +: 3];

   // ==========================================================
   // FIFO capacity, trigger level and flags
   wire [5:0] capacity = loop_en ? 6'(ir_tx_pkg::LOOP_DEPTH)
                                 : 6'(ir_tx_pkg::FIFO_DEPTH);
   wire [5:0] trig_lvl = loop_en ? ir_tx_pkg::LVL16[level_sel]
                                 : ir_tx_pkg::LVL32[level_sel];
   wire       full     = count_reg >= capacity;
   wire       empty    = count_reg == 6'h00;
   wire       push     = wr_en & hit_dat & ~full & ~flush_req;
   wire       overflow = wr_en & hit_dat & full;
   wire       pop      = state_reg == ir_tx_pkg::ST_LOAD & ~empty &
                         ~flush_req;
   wire       below    = count_reg < trig_lvl;

   // Deferral: start only on full FIFO or idle timeout
   wire timed_out = idle_cnt_reg >= 12'(ir_tx_pkg::TX_TIMEOUT_CYC);
   wire may_start = ~empty & (~defer_en | full | timed_out);

   // ==========================================================
   // Carrier period table and pulse width
   wire [15:0] lo_period [32];
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_period
         // Low band steps 1 kHz per code
         assign lo_period[g] =
            16'(ir_tx_pkg::CLK_KHZ / (ir_tx_pkg::LOW_BASE_KHZ + g));
      end
   endgenerate
   // High band has four codes; others fall back to the default
   wire [15:0] hi_period =
      freq_code == ir_tx_pkg::CODE_400 ?
         16'(ir_tx_pkg::CLK_KHZ / ir_tx_pkg::HI_400_KHZ) :
      freq_code == ir_tx_pkg::CODE_450 ?
         16'(ir_tx_pkg::CLK_KHZ / ir_tx_pkg::HI_450_KHZ) :
      freq_code == ir_tx_pkg::CODE_500 ?
         16'(ir_tx_pkg::CLK_KHZ / ir_tx_pkg::HI_500_KHZ) :
         16'(ir_tx_pkg::CLK_KHZ / ir_tx_pkg::HI_480_KHZ);
   wire [15:0] car_period = band_reg ? hi_period
                                     : lo_period[freq_code];
   // Reserved width codes fall back to the default code
   wire        width_ok  = width_sel >= 3'h2 && width_sel <= 3'h6;
   wire [2:0]  width_idx = (width_ok ? width_sel
                                     : ir_tx_pkg::WIDTH_DEFAULT) - 3'h2;
   wire [15:0] width_cyc = band_reg ?
      16'(ir_tx_pkg::PW_HI_NS[width_idx] * ir_tx_pkg::CLK_MHZ / 1000) :
      16'(ir_tx_pkg::PW_LO_NS[width_idx] * ir_tx_pkg::CLK_MHZ / 1000);
   // High time capped below the period so a low phase always remains
   wire [15:0] high_cyc = width_cyc < car_period ? width_cyc
                                     : car_period - 16'h0001;

   // ==========================================================
   // Bit and pulse sequencing
   wire       cur_bit  = runlen_byte_reg ? shift_reg[7] : shift_reg[0];
   wire       bit_end  = bit_cnt_reg >= period_reg - 16'h0001;
   wire       car_wrap = car_cnt_reg >= car_period - 16'h0001;
   wire       last_bit = bits_left_reg == 8'h01;
   wire [3:0] pulse_max = style == 2'b01 ? 4'(ir_tx_pkg::PULSES_8) :
                          4'(ir_tx_pkg::PULSES_6);
   wire       pulses_on = style == 2'b00 ||
                          (style != 2'b11 && pulse_cnt_reg < pulse_max);
   wire       carrier_on = state_reg == ir_tx_pkg::ST_SEND & ~cur_bit &
                           pulses_on & car_cnt_reg < high_cyc;
   wire       done_evt = state_reg == ir_tx_pkg::ST_LOAD & empty;
   wire [7:0] head     = fifo_mem[rd_ptr_reg];

   // ==========================================================
   // Control registers; flush bit acts once and reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_reg     <= ir_tx_pkg::CTRL1_RESET;
         ctrl2_reg     <= ir_tx_pkg::CTRL2_RESET;
         period_reg    <= ir_tx_pkg::PERIOD_RESET;
         band_reg      <= 1'b0;
         lowirq_en_reg <= 1'b0;
         irq_mask_reg  <= 3'h0;
      end else begin
         if (wr_en && hit_c1) begin
            ctrl1_reg <= pwdata[7:0];
         end
         // Last assignment wins, so the flush bit never holds a one
         ctrl1_reg[ir_tx_pkg::FLUSH_BIT] <= 1'b0;
         if (wr_en && hit_c2) begin
            ctrl2_reg <= pwdata[7:0];
         end
         if (wr_en && hit_im) begin
            irq_mask_reg <= pwdata[2:0];
         end
         if (wr_en && hit_aux) begin
            band_reg      <= pwdata[ir_tx_pkg::BAND_BIT];
            lowirq_en_reg <= pwdata[ir_tx_pkg::LOWIRQ_EN_BIT];
            period_reg    <= pwdata[ir_tx_pkg::PERIOD_LSB +: 16];
         end
      end
   end

   // Sticky event flags; a new event wins over write-one-to-clear
   wire [2:0] evt = {done_evt, overflow,
                     below & lowirq_en_reg};
   wire [2:0] w1c = (wr_en && hit_is) ? pwdata[2:0] : 3'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= 3'h0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~w1c) | evt;
      end
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // FIFO storage, written without reset
   always_ff @(posedge pclk) begin
      if (push) begin
         fifo_mem[wr_ptr_reg] <= pwdata[7:0];
      end
   end

   // FIFO pointers; flush empties at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_reg <= 5'h00;
         rd_ptr_reg <= 5'h00;
         count_reg  <= 6'h00;
      end else if (flush_req) begin
         wr_ptr_reg <= 5'h00;
         rd_ptr_reg <= 5'h00;
         count_reg  <= 6'h00;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + 5'(push);
         rd_ptr_reg <= rd_ptr_reg + 5'(pop);
         count_reg  <= count_reg + 6'(push) - 6'(pop);
      end
   end

   // Idle time since last write, for the deferral timeout
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_reg <= 12'h000;
      end else if (push || empty) begin
         idle_cnt_reg <= 12'h000;
      end else if (!timed_out) begin
         idle_cnt_reg <= idle_cnt_reg + 12'h001;
      end
   end

   // ==========================================================
   // Transmit state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg       <= ir_tx_pkg::ST_IDLE;
         shift_reg       <= 8'h00;
         bits_left_reg   <= 8'h00;
         runlen_byte_reg <= 1'b0;
      end else if (flush_req) begin
         state_reg <= ir_tx_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            ir_tx_pkg::ST_IDLE: begin
               if (may_start) begin
                  state_reg <= ir_tx_pkg::ST_LOAD;
               end
            end
            ir_tx_pkg::ST_LOAD: begin
               if (empty) begin
                  state_reg <= ir_tx_pkg::ST_IDLE;
               end else begin
                  state_reg       <= ir_tx_pkg::ST_SEND;
                  shift_reg       <= head;
                  runlen_byte_reg <= runlen_en;
                  // Run length is stored minus one
                  bits_left_reg   <= runlen_en ?
                     {1'b0, head[6:0]} + 8'h01 : 8'h08;
               end
            end
            ir_tx_pkg::ST_SEND: begin
               if (bit_end) begin
                  bits_left_reg <= bits_left_reg - 8'h01;
                  if (!runlen_byte_reg) begin
                     shift_reg <= {1'b1, shift_reg[7:1]};
                  end
                  if (last_bit) begin
                     state_reg <= ir_tx_pkg::ST_LOAD;
                  end
               end
            end
            default: begin
               state_reg <= ir_tx_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Bit timer, carrier counter and pulse count per bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_reg   <= 16'h0000;
         car_cnt_reg   <= 16'h0000;
         pulse_cnt_reg <= 4'h0;
      end else if (state_reg != ir_tx_pkg::ST_SEND || bit_end) begin
         bit_cnt_reg   <= 16'h0000;
         car_cnt_reg   <= 16'h0000;
         pulse_cnt_reg <= 4'h0;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 16'h0001;
         car_cnt_reg <= car_wrap ? 16'h0000 : car_cnt_reg + 16'h0001;
         if (car_wrap && pulse_cnt_reg != 4'hF) begin
            pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
         end
      end
   end

   // Read selection
   wire [31:0] rd_mux =
      hit_c1  ? {24'h000000, ctrl1_reg} :
      hit_c2  ? {24'h000000, ctrl2_reg} :
      hit_st  ? {22'h0, state_reg, count_reg, full, empty} :
      hit_is  ? {29'h0, irq_stat_reg} :
      hit_im  ? {29'h0, irq_mask_reg} :
      hit_aux ? {period_reg, 14'h0, lowirq_en_reg, band_reg} :
                32'h0000_0000;

   // Registered modulated output and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_mod_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         tx_mod_reg <= carrier_on;
         if (rd_setup) begin
            prdata_reg <= rd_mux;
         end
      end
   end
   // Loopback keeps the emitter dark
   assign ir_tx_out = tx_mod_reg & ~loop_en;
   assign loop_out  = tx_mod_reg & loop_en;
   assign prdata    = prdata_reg;

   // ==========================================================
   // Assertions, all on pclk and off during reset
   default clocking chk_clk @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_flush_empties: assert property (flush_req |=>
      count_reg == 6'h00 && !ctrl1_reg[ir_tx_pkg::FLUSH_BIT])
      else $error("flush did not empty FIFO");
   a_loop_dark: assert property (loop_en |-> !ir_tx_out)
      else $error("emitter driven in loopback");
   a_fifo_cap: assert property (
      count_reg <= (loop_en ? 6'h10 : 6'h20))
      else $error("FIFO above capacity");
   a_level_map: assert property (level_sel == 2'b11 |->
      trig_lvl == (loop_en ? 6'h0D : 6'h19))
      else $error("wrong trigger level");
   a_runlen_load: assert property (pop && runlen_en |=>
      bits_left_reg == {1'b0, $past(head[6:0])} + 8'h01)
      else $error("run length not loaded");
   a_defer_hold: assert property (
      state_reg == ir_tx_pkg::ST_IDLE && defer_en && !full && !timed_out
      |=> state_reg == ir_tx_pkg::ST_IDLE)
      else $error("deferral did not hold data");
   a_six_pulses: assert property (
      style == 2'b10 && pulse_cnt_reg >= 4'h6 |-> !carrier_on)
      else $error("pulse beyond six");
   a_ctrl2_reset: assert property ($rose(presetn) |->
      freq_code == 5'h0B && width_sel == 3'h4)
      else $error("carrier code reset wrong");
   a_duty_cap: assert property (
      high_cyc < car_period && high_cyc <= width_cyc)
      else $error("duty not bounded");
   a_high_480: assert property (
      band_reg && freq_code == 5'h0B |-> car_period == 16'h0208)
      else $error("480 kHz period wrong");
   a_low_irq: assert property (
      below && lowirq_en_reg |=> irq_stat_reg[0])
      else $error("low level flag missed");
endmodule

// [ir_tx_pkg.sv]
// Constants, register map and types of the infrared transmit controller.
// Assumes a 250 MHz APB clock and one 32-byte transmit FIFO.
package ir_tx_pkg;
   // =========================================================
   // Register indices; byte address is four times the index
   localparam logic [7:0] TX_CTRL1_IDX  = 8'h03;
   localparam logic [7:0] TX_CTRL2_IDX  = 8'h04;
   localparam logic [7:0] TX_DATA_IDX   = 8'h08;
   localparam logic [7:0] TX_STAT_IDX   = 8'h09;
   localparam logic [7:0] IRQ_STAT_IDX  = 8'h0A;
   localparam logic [7:0] IRQ_MASK_IDX  = 8'h0B;
   localparam logic [7:0] AUX_CTRL_IDX  = 8'h0C;
   // =========================================================
   // Field positions and reset values
   localparam int FLUSH_BIT     = 7;
   localparam int LOOP_BIT      = 6;
   localparam int LEVEL_LSB     = 4;
   localparam int RUNLEN_BIT    = 3;
   localparam int DEFER_BIT     = 2;
   localparam int STYLE_LSB     = 0;
   localparam int FREQ_LSB      = 3;
   localparam int WIDTH_LSB     = 0;
   localparam int BAND_BIT      = 0;
   localparam int LOWIRQ_EN_BIT = 1;
   localparam int PERIOD_LSB    = 16;
   localparam logic [7:0]  CTRL1_RESET  = 8'h00;
   localparam logic [7:0]  CTRL2_RESET  = 8'h5C;  // Code 01011, width 100
   localparam logic [15:0] PERIOD_RESET = 16'h2710;
   localparam logic [2:0]  WIDTH_DEFAULT = 3'h4;
   localparam int IRQ_LOW   = 0;
   localparam int IRQ_OVF   = 1;
   localparam int IRQ_DONE  = 2;
   localparam int IRQ_BITS  = 3;
   // =========================================================
   // FIFO sizes and trigger levels
   localparam int FIFO_DEPTH = 32;
   localparam int LOOP_DEPTH = 16;
   localparam logic [5:0] LVL16 [4] = '{6'h01, 6'h03, 6'h07, 6'h0D};
   localparam logic [5:0] LVL32 [4] = '{6'h01, 6'h07, 6'h0F, 6'h19};
   // =========================================================
   // Timing: clock, carrier and pulse widths
   localparam int CLK_MHZ      = 250;
   localparam int CLK_KHZ      = CLK_MHZ * 1000;
   localparam int LOW_BASE_KHZ = 27;
   localparam int HI_400_KHZ   = 400;
   localparam int HI_450_KHZ   = 450;
   localparam int HI_480_KHZ   = 480;
   localparam int HI_500_KHZ   = 500;
   localparam logic [4:0] CODE_400 = 5'h03;
   localparam logic [4:0] CODE_450 = 5'h08;
   localparam logic [4:0] CODE_500 = 5'h0D;
   localparam int PW_LO_NS [5] = '{6000, 7000, 8700, 10600, 13300};
   localparam int PW_HI_NS [5] = '{700, 800, 900, 1000, 1160};
   localparam int PULSES_8 = 8;
   localparam int PULSES_6 = 6;
   localparam int TX_TIMEOUT_NS  = 16000;
   localparam int TX_TIMEOUT_CYC = TX_TIMEOUT_NS * CLK_MHZ / 1000;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_SEND = 2'b11
   } tx_state_t;
endpackage

// [tb_ir_tx_ctrl.sv]
// Testbench of the infrared transmit controller over APB.
// Assumes a pclk-synchronous APB slave and emitter models on both outputs.
`timescale 1ns/1ps
module tb_ir_tx_ctrl;
   // ========================================================
   // Signals and models
   logic        pclk, presetn, psel, penable, pwrite, em_clr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic        pready, pslverr, ir_tx_out, loop_out, irq, e;
   int          errors, checked, cycles, tx_p, tx_h, lp_p, lp_h;
   int          exp_p [4] = '{0, 16, 12, 0};

   ir_tx_ctrl ir_tx_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ir_tx_out(ir_tx_out), .loop_out(loop_out), .irq(irq));
   ir_emitter_model ir_emitter_model_i (.pclk(pclk), .presetn(presetn),
      .clr(em_clr), .ir_tx_out(ir_tx_out), .pulses(tx_p), .high_len(tx_h));
   ir_emitter_model loop_model_i (.pclk(pclk), .presetn(presetn),
      .clr(em_clr), .ir_tx_out(loop_out), .pulses(lp_p), .high_len(lp_h));

   // Clock of 4 ns
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // ========================================================
   // Tasks
   task test_done;
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task check(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Hold the access until ready; only the hang guard ends a stall
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wait_done;
      int n;
      n = 0;
      d = 32'h0;
      while (d[2] !== 1'b1 && n < 4000) begin
         apb(1'b0, ir_tx_pkg::IRQ_STAT_IDX, 32'h0);
         n++;
      end
      check("done flag", d[2], 1'b1);
      apb(1'b1, ir_tx_pkg::IRQ_STAT_IDX, 32'h7);
   endtask

   task send(input logic [7:0] c1, input logic [7:0] b);
      apb(1'b1, ir_tx_pkg::TX_CTRL1_IDX, {24'h0, c1});
      em_clr <= 1'b1;
      @(posedge pclk);
      em_clr <= 1'b0;
      apb(1'b1, ir_tx_pkg::TX_DATA_IDX, {24'h0, b});
      wait_done;
   endtask

   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 90000) begin
         errors++;
         test_done;
      end
   end

   // ========================================================
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, em_clr} = 5'h0;
      paddr  = 12'h000;
      pwdata = 32'h0;
      errors = 0;
      checked = 0;
      cycles = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ir_tx_pkg::TX_CTRL1_IDX, 32'h0);
      check("ctrl1 reset", d, 32'h00);
      apb(1'b0, ir_tx_pkg::TX_CTRL2_IDX, 32'h0);
      check("ctrl2 reset", d, 32'h5C);
      apb(1'b0, 8'h3F, 32'h0);
      check("unmapped err", e, 1'b1);
      // Trigger level against a queue of three deferred bytes
      apb(1'b1, ir_tx_pkg::AUX_CTRL_IDX, 32'h1388_0002);
      apb(1'b1, ir_tx_pkg::TX_CTRL1_IDX, 32'h04);
      repeat (3) apb(1'b1, ir_tx_pkg::TX_DATA_IDX, 32'hFF);
      apb(1'b1, ir_tx_pkg::IRQ_STAT_IDX, 32'h7);
      apb(1'b0, ir_tx_pkg::IRQ_STAT_IDX, 32'h0);
      check("low flag lvl1", d[0], 1'b0);
      apb(1'b1, ir_tx_pkg::TX_CTRL1_IDX, 32'h34);
      apb(1'b0, ir_tx_pkg::TX_STAT_IDX, 32'h0);
      check("count", d[7:2], 6'h03);
      apb(1'b0, ir_tx_pkg::IRQ_STAT_IDX, 32'h0);
      check("low flag lvl25", d[0], 1'b1);
      apb(1'b1, ir_tx_pkg::IRQ_MASK_IDX, 32'h1);
      #1 check("irq on", irq, 1'b1);
      apb(1'b1, ir_tx_pkg::IRQ_MASK_IDX, 32'h0);
      #1 check("irq off", irq, 1'b0);
      // Loopback depth, level code 01: three bytes are not below it
      apb(1'b1, ir_tx_pkg::TX_CTRL1_IDX, 32'h54);
      apb(1'b1, ir_tx_pkg::IRQ_STAT_IDX, 32'h7);
      apb(1'b0, ir_tx_pkg::IRQ_STAT_IDX, 32'h0);
      check("low flag lvl3", d[0], 1'b0);
      // Flush empties the queue and clears itself
      apb(1'b1, ir_tx_pkg::TX_CTRL1_IDX, 32'h80);
      apb(1'b0, ir_tx_pkg::TX_CTRL1_IDX, 32'h0);
      check("flush clears", d, 32'h00);
      apb(1'b0, ir_tx_pkg::TX_STAT_IDX, 32'h0);
      check("flushed", d[7:0], 8'h01);
      // Loopback depth: sixteen bytes fill and start the send, which
      // pops one; the seventeenth refills, the eighteenth overflows
      apb(1'b1, ir_tx_pkg::TX_CTRL1_IDX, 32'h44);
      repeat (18) apb(1'b1, ir_tx_pkg::TX_DATA_IDX, 32'h80);
      apb(1'b0, ir_tx_pkg::IRQ_STAT_IDX, 32'h0);
      check("overflow", d[1], 1'b1);
      apb(1'b1, ir_tx_pkg::TX_CTRL1_IDX, 32'h80);
      // Deferral holds a single byte until the time-out
      apb(1'b1, ir_tx_pkg::AUX_CTRL_IDX, 32'h0100_0000);
      apb(1'b1, ir_tx_pkg::IRQ_STAT_IDX, 32'h7);
      apb(1'b1, ir_tx_pkg::TX_CTRL1_IDX, 32'h0C);
      apb(1'b1, ir_tx_pkg::TX_DATA_IDX, 32'h80);
      repeat (3800) @(posedge pclk);
      apb(1'b0, ir_tx_pkg::TX_STAT_IDX, 32'h0);
      check("deferred", d[7:2], 6'h01);
      wait_done;
      // Pulse styles on two run-length zero bits, high band
      apb(1'b1, ir_tx_pkg::AUX_CTRL_IDX, 32'h1388_0001);
      for (int s = 1; s < 4; s++) begin
         send(8'h08 | s[7:0], 8'h01);
         check("pulse count", tx_p, exp_p[s]);
      end
      send(8'h08, 8'h00);
      check("hi pulses", tx_p, 32'd10);
      check("hi width", tx_h, 32'd225);
      // Low band, slowest carrier, shortest width
      apb(1'b1, ir_tx_pkg::AUX_CTRL_IDX, 32'h1388_0000);
      apb(1'b1, ir_tx_pkg::TX_CTRL2_IDX, 32'h02);
      send(8'h08, 8'h00);
      check("lo pulses", tx_p, 32'd1);
      check("lo width", tx_h, 32'd1500);
      // Loopback routes the carrier away from the emitter
      apb(1'b1, ir_tx_pkg::TX_CTRL2_IDX, 32'h5C);
      apb(1'b1, ir_tx_pkg::AUX_CTRL_IDX, 32'h1388_0001);
      send(8'h48, 8'h00);
      check("emitter dark", tx_p, 32'd0);
      check("loop pulses", lp_p, 32'd10);
      apb(1'b0, ir_tx_pkg::TX_CTRL1_IDX, 32'h0);
      check("loop bit", d, 32'h48);
      apb(1'b1, ir_tx_pkg::TX_CTRL1_IDX, 32'h00);
      // Plain byte, short bit time: zero bits 0 and 3 give two bursts each
      apb(1'b1, ir_tx_pkg::AUX_CTRL_IDX, 32'h0400_0001);
      send(8'h00, 8'hF6);
      check("byte pulses", tx_p, 32'h4);
      test_done;
   end
endmodule
